// ===== shared/rtc_pin_pkg.sv
// constants shared by both ends of the rtc pin-side link
package rtc_pin_pkg;
  // clock and divider timing
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int DIV_TICK_HZ = 65536;
  localparam int TICK_CYCLES = SYS_CLK_HZ / DIV_TICK_HZ;
  localparam int DIV_STAGES = 15;
  // host strobe timing in clock cycles
  localparam int STROBE_CYCLES = 3;
  // device register addresses
  localparam logic [7:0] REG_A_ADDR = 8'h0a;
  localparam logic [7:0] REG_B_ADDR = 8'h0b;
  localparam logic [7:0] REG_C_ADDR = 8'h0c;
  localparam logic [7:0] REG_D_ADDR = 8'h0d;
  localparam logic [7:0] RAM_FIRST_ADDR = 8'h0e;
  localparam int RAM_BYTES = 114;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'h4b;
  // register a fields
  localparam int RATE_LSB = 0;
  localparam int BANK_BIT = 4;
  localparam int DIV_CTRL_BIT = 5;
  // register b fields
  localparam int SQW_EN_BIT = 3;
  localparam int IRQ_EN_LSB = 4;
  // register c / d fields
  localparam int FLAG_LSB = 4;
  localparam int IRQF_BIT = 7;
  localparam int VALID_RAM_BIT = 7;
  localparam int EVENT_COUNT = 3;
  // extended control fields
  localparam int AUX_EN_BIT = 7;
  localparam int FAST_CLK_BIT = 6;
  localparam int WAKE_IRQ_EN_BIT = 5;
  localparam int WAKE_FLAG_BIT = 4;
  localparam int SUPPLY_OFF_BIT = 0;
  // reset, wipe and idle-bus values
  localparam logic [7:0] REG_A_RST = 8'h00;
  localparam logic [7:0] REG_B_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] RAM_WIPE_VAL = 8'hff;
  localparam logic [7:0] BUS_IDLE_VAL = 8'hff;
  // host wishbone map
  localparam logic [3:0] HOST_CMD_ADDR = 4'h0;
  localparam logic [3:0] HOST_STATUS_ADDR = 4'h4;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_START_BIT = 17;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_SUPPLY_BIT = 2;
  localparam int STAT_DATA_LSB = 8;
endpackage

// ===== shared/rtc_pin_if.sv
// pin-level link between host processor and rtc device
`timescale 1ns/100ps
interface rtc_pin_if;
  logic ale;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic [7:0] host_ad;
  logic host_ad_oe;
  logic [7:0] dev_ad;
  logic dev_ad_oe;
  logic irq_oe;
  logic supply_oe;
  logic square_wave_out;
  logic square_wave_oe;
  logic wake_key_n;
  logic user_ram_wipe_n;
  // resolved wire levels; undriven lines read as pulled up
  logic [7:0] ad_line;
  logic irq_line_n;
  logic supply_on_n;
  assign ad_line = host_ad_oe ? host_ad : (dev_ad_oe ? dev_ad : 8'hff);
  assign irq_line_n = ~irq_oe;
  assign supply_on_n = ~supply_oe;
  modport device (input ale, cs_n, wr_n, rd_n, ad_line, wake_key_n, user_ram_wipe_n,
                  output dev_ad, dev_ad_oe, irq_oe, supply_oe, square_wave_out,
                  square_wave_oe);
  modport host (output ale, cs_n, wr_n, rd_n, host_ad, host_ad_oe,
                input ad_line, irq_line_n, supply_on_n);
endinterface

// ===== hw/rtc_device_end.sv
// rtc device end: bus strobes, interrupt, wake key, ram wipe, square wave
`timescale 1ns/100ps
module rtc_device_end
  import rtc_pin_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  rtc_pin_if.device PINS,
  input wire logic VCC_OK_IN,
  input wire logic AUX_SUPPLY_IN,
  input wire logic [EVENT_COUNT-1:0] EVENT_FLAGS_IN,
  output logic DIVIDER_RUN_OUT
);
  initial begin
    if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 65536) begin
      $error("TICK_CYCLES_P must be 1..65536");
    end
  end

  logic ale_q_r, wr_q_r, rd_q_r, vcc_q_r;
  logic wk_s1_r, wk_s2_r, wk_q_r, wipe_s1_r, wipe_s2_r;
  logic [7:0] addr_r, reg_a_r, reg_b_r, ext_r, dev_ad_r;
  logic [EVENT_COUNT-1:0] flags_r;
  logic dev_ad_oe_r, irq_oe_r, supply_oe_r, sq_out_r, sq_oe_r;
  logic [15:0] tick_cnt_r;
  logic [DIV_STAGES-1:0] chain_r;
  logic [7:0] ram_r [RAM_BYTES];
  logic [7:0] ram_idx, rd_data;
  logic access_ok, wr_rise, rd_fall, ext_sel, ram_sel, vcc_rise, wk_fall, tap_bit;
  logic [3:0] rate;

  // access gating: low supply or missing select blocks reads and writes; the address latch is not gated
  assign access_ok = ~PINS.cs_n & VCC_OK_IN;
  assign wr_rise = ~wr_q_r & PINS.wr_n & access_ok;
  assign rd_fall = rd_q_r & ~PINS.rd_n & access_ok;
  assign ext_sel = reg_a_r[BANK_BIT] & (addr_r == EXT_CTRL_ADDR);
  assign ram_sel = (addr_r >= RAM_FIRST_ADDR) & ~addr_r[7] & ~ext_sel;
  assign ram_idx = addr_r - RAM_FIRST_ADDR;
  assign vcc_rise = VCC_OK_IN & ~vcc_q_r;
  assign wk_fall = wk_q_r & ~wk_s2_r;
  assign rate = reg_a_r[RATE_LSB +: 4];
  // edge history of strobes and supply
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ale_q_r <= 1'b0;
      wr_q_r <= 1'b1;
      rd_q_r <= 1'b1;
      vcc_q_r <= 1'b0;
    end else begin
      ale_q_r <= PINS.ale;
      wr_q_r <= PINS.wr_n;
      rd_q_r <= PINS.rd_n;
      vcc_q_r <= VCC_OK_IN;
    end
  end
  // synchronisers; the second stage feeds logic, and the wake key edge also uses a third stage
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wk_s1_r <= 1'b1;
      wk_s2_r <= 1'b1;
      wk_q_r <= 1'b1;
      wipe_s1_r <= 1'b1;
      wipe_s2_r <= 1'b1;
    end else begin
      wk_s1_r <= PINS.wake_key_n;
      wk_s2_r <= wk_s1_r;
      wk_q_r <= wk_s2_r;
      wipe_s1_r <= PINS.user_ram_wipe_n;
      wipe_s2_r <= wipe_s1_r;
    end
  end
  // address latch works even without select, as the bus demands
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      addr_r <= 8'h00;
    end else if (ale_q_r && !PINS.ale) begin
      addr_r <= PINS.ad_line;
    end
  end
  // register a; supply rise sets the divider control bit that drives DIVIDER_RUN_OUT
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      reg_a_r <= REG_A_RST;
    end else begin
      if (wr_rise && addr_r == REG_A_ADDR) begin
        reg_a_r <= PINS.ad_line;
      end
      if (vcc_rise) begin
        reg_a_r[DIV_CTRL_BIT] <= 1'b1;
      end
    end
  end
  // register b: square wave enable and interrupt enables
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      reg_b_r <= REG_B_RST;
    end else if (wr_rise && addr_r == REG_B_ADDR) begin
      reg_b_r <= PINS.ad_line;
    end
  end
  // event flags clear on a read of register c; a new event wins
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      flags_r <= '0;
    end else begin
      if (rd_fall && addr_r == REG_C_ADDR) begin
        flags_r <= EVENT_FLAGS_IN;
      end else begin
        flags_r <= flags_r | EVENT_FLAGS_IN;
      end
    end
  end
  // extended control in bank 1; wake flag is write-one-to-clear
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_r <= EXT_CTRL_RST;
    end else begin
      if (wr_rise && ext_sel) begin
        ext_r[7:5] <= PINS.ad_line[7:5];
        if (PINS.ad_line[WAKE_FLAG_BIT]) begin
          ext_r[WAKE_FLAG_BIT] <= 1'b0;
        end
      end
      if (vcc_rise) begin
        ext_r[FAST_CLK_BIT] <= 1'b1;
      end
      if (wk_fall && VCC_OK_IN) begin
        ext_r[WAKE_FLAG_BIT] <= 1'b1;
      end
    end
  end
  // supply-on is latched by the wake key and released only by software
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      supply_oe_r <= 1'b0;
    end else if (wk_fall && !VCC_OK_IN && ext_r[AUX_EN_BIT] && AUX_SUPPLY_IN) begin
      supply_oe_r <= 1'b1;
    end else if (wr_rise && ext_sel && PINS.ad_line[SUPPLY_OFF_BIT]) begin
      supply_oe_r <= 1'b0;
    end
  end
  // general ram; the wipe ignores supply state and bus gating
  generate
    for (genvar i = 0; i < RAM_BYTES; i++) begin : g_ram
      always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          ram_r[i] <= 8'h00;
        end else if (!wipe_s2_r) begin
          ram_r[i] <= RAM_WIPE_VAL;
        end else if (wr_rise && ram_sel && ram_idx == 8'(i)) begin
          ram_r[i] <= PINS.ad_line;
        end
      end
    end
  endgenerate
  // read multiplexer
  always_comb begin
    rd_data = 8'h00;
    if (ram_sel) begin
      rd_data = ram_r[ram_idx[6:0]];
    end else if (ext_sel) begin
      rd_data = {ext_r[7:4], 4'h0};
    end else begin
      case (addr_r)
        REG_A_ADDR: rd_data = reg_a_r;
        REG_B_ADDR: rd_data = reg_b_r;
        REG_C_ADDR: rd_data = {irq_oe_r, 3'b000 | flags_r, 4'h0};
        REG_D_ADDR: rd_data = 8'h80;
        default: rd_data = 8'h00;
      endcase
    end
  end
  // drivers lag fetch a cycle; the byte is frozen at fetch start so clear-on-read data holds
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dev_ad_oe_r <= 1'b0;
      dev_ad_r <= 8'h00;
    end else begin
      dev_ad_oe_r <= ~PINS.rd_n & access_ok;
      dev_ad_r <= rd_fall ? rd_data : dev_ad_r;
    end
  end
  // open-drain interrupt: pulled low only while an enabled flag stands
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= (|(flags_r & reg_b_r[IRQ_EN_LSB +: EVENT_COUNT])) |
                  (ext_r[WAKE_FLAG_BIT] & ext_r[WAKE_IRQ_EN_BIT]);
    end
  end
  // divider chain; bit 0 toggles at 32768 Hz
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tick_cnt_r <= 16'h0000;
      chain_r <= '0;
    end else if (tick_cnt_r == 16'(TICK_CYCLES_P - 1)) begin
      tick_cnt_r <= 16'h0000;
      chain_r <= chain_r + 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  // rate 1 and 2 reuse the 256 and 128 Hz taps, rate 0 is off
  always_comb begin
    case (rate)
      4'h0: tap_bit = 1'b0;
      4'h1: tap_bit = chain_r[7];
      4'h2: tap_bit = chain_r[8];
      default: tap_bit = chain_r[rate - 4'h1];
    endcase
  end
  // square wave pin; driven low when disabled only while supplied
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sq_out_r <= 1'b0;
      sq_oe_r <= 1'b0;
    end else if (VCC_OK_IN) begin
      sq_oe_r <= 1'b1;
      if (ext_r[FAST_CLK_BIT]) begin
        sq_out_r <= chain_r[0];
      end else if (reg_b_r[SQW_EN_BIT]) begin
        sq_out_r <= tap_bit;
      end else begin
        sq_out_r <= 1'b0;
      end
    end else if (ext_r[FAST_CLK_BIT] && ext_r[AUX_EN_BIT] && AUX_SUPPLY_IN) begin
      sq_oe_r <= 1'b1;
      sq_out_r <= chain_r[0];
    end else begin
      sq_oe_r <= 1'b0;
      sq_out_r <= 1'b0;
    end
  end
  // pin and user outputs straight from flops
  assign PINS.dev_ad = dev_ad_r;
  assign PINS.dev_ad_oe = dev_ad_oe_r;
  assign PINS.irq_oe = irq_oe_r;
  assign PINS.supply_oe = supply_oe_r;
  assign PINS.square_wave_out = sq_out_r;
  assign PINS.square_wave_oe = sq_oe_r;
  assign DIVIDER_RUN_OUT = reg_a_r[DIV_CTRL_BIT];
endmodule // rtc_device_end

// ===== hw/rtc_host_end.sv
// host end: wishbone command registers driving the multiplexed rtc bus
`timescale 1ns/100ps
module rtc_host_end
  import rtc_pin_pkg::*;
#(
  parameter int STROBE_CYCLES_P = STROBE_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  rtc_pin_if.host PINS,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT
);
  initial begin
    if (STROBE_CYCLES_P < 2 || STROBE_CYCLES_P > 255) begin
      $error("STROBE_CYCLES_P must be 2..255");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_GAP = 3'b011,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b110
  } host_state_t;

  host_state_t state_r;
  logic [7:0] cmd_addr_r, cmd_data_r, rdata_r, host_ad_r, cnt_r;
  logic cmd_write_r, ack_r, go, wb_req;
  logic ale_r, cs_n_r, wr_n_r, rd_n_r, host_ad_oe_r;
  logic [31:0] dat_out_r;

  assign wb_req = WB_CYC_IN & WB_STB_IN & ~ack_r;
  // a start while busy is dropped rather than queued
  assign go = wb_req & WB_WE_IN & (WB_ADR_IN == HOST_CMD_ADDR) & WB_SEL_IN[2] &
              WB_DAT_IN[CMD_START_BIT] & (state_r == ST_IDLE);

  // wishbone slave: one-cycle ack, unmapped reads return zero
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_r <= 1'b0;
      dat_out_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        case (WB_ADR_IN)
          HOST_CMD_ADDR: dat_out_r <= {15'h0000, cmd_write_r, cmd_data_r, cmd_addr_r};
          HOST_STATUS_ADDR: dat_out_r <= {16'h0000, rdata_r, 5'h00, ~PINS.supply_on_n,
                                          ~PINS.irq_line_n, state_r != ST_IDLE};
          default: dat_out_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // command fields, byte-lane writable
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cmd_addr_r <= 8'h00;
      cmd_data_r <= 8'h00;
      cmd_write_r <= 1'b0;
    end else if (wb_req && WB_WE_IN && WB_ADR_IN == HOST_CMD_ADDR) begin
      if (WB_SEL_IN[0]) begin
        cmd_addr_r <= WB_DAT_IN[7:0];
      end
      if (WB_SEL_IN[1]) begin
        cmd_data_r <= WB_DAT_IN[15:8];
      end
      if (WB_SEL_IN[2]) begin
        cmd_write_r <= WB_DAT_IN[CMD_WRITE_BIT];
      end
    end
  end

  // bus cycle sequencer; select spans the gap, the data strobe and the hold cycle, not the latch pulse
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      ale_r <= 1'b0;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      host_ad_oe_r <= 1'b0;
      host_ad_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cs_n_r <= 1'b1;
          host_ad_oe_r <= 1'b0;
          if (go) begin
            state_r <= ST_ADDR;
            ale_r <= 1'b1;
            host_ad_oe_r <= 1'b1;
            host_ad_r <= WB_SEL_IN[0] ? WB_DAT_IN[7:0] : cmd_addr_r;
          end
        end
        ST_ADDR: begin
          state_r <= ST_GAP;
          ale_r <= 1'b0;
          cs_n_r <= 1'b0;
        end
        ST_GAP: begin
          state_r <= ST_STROBE;
          cnt_r <= 8'h00;
          if (cmd_write_r) begin
            wr_n_r <= 1'b0;
            host_ad_r <= cmd_data_r;
          end else begin
            rd_n_r <= 1'b0;
            host_ad_oe_r <= 1'b0;
          end
        end
        ST_STROBE: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(STROBE_CYCLES_P - 1)) begin
            state_r <= ST_HOLD;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            if (!cmd_write_r) begin
              rdata_r <= PINS.ad_line;
            end
          end
        end
        ST_HOLD: begin
          state_r <= ST_IDLE;
          cs_n_r <= 1'b1;
          host_ad_oe_r <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign PINS.ale = ale_r;
  assign PINS.cs_n = cs_n_r;
  assign PINS.wr_n = wr_n_r;
  assign PINS.rd_n = rd_n_r;
  assign PINS.host_ad = host_ad_r;
  assign PINS.host_ad_oe = host_ad_oe_r;
  assign WB_DAT_OUT = dat_out_r;
  assign WB_ACK_OUT = ack_r;
endmodule // rtc_host_end

// ===== verif/rtc_pin_monitor.sv
// concurrent checks on the pin link between host end and device end
`timescale 1ns/100ps
module rtc_pin_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic VCC_OK_IN,
  input wire logic AUX_SUPPLY_IN,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic irq_oe,
  input wire logic supply_oe,
  input wire logic square_wave_oe,
  input wire logic wake_key_n
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // store strobe of the default width, select kept through it and the hold cycle
  sequence store_hold_s;
    (!wr_n && !cs_n)[*3] ##1 (wr_n && !cs_n);
  endsequence
  // one-cycle latch pulse, then select in the gap cycle
  sequence latch_gap_s;
    ale ##1 (!ale && !cs_n);
  endsequence
  wr_strobe_a: assert property ($fell(wr_n) |-> store_hold_s)
    else $error("store strobe shape wrong");
  addr_latch_a: assert property ($rose(ale) |-> latch_gap_s)
    else $error("latch pulse shape wrong");
  select_held_a: assert property ((!wr_n || !rd_n) |-> !cs_n)
    else $error("strobe without select");
  // both drivers on at once would fight on the shared lines
  bus_share_a: assert property (!(host_ad_oe && dev_ad_oe))
    else $error("two drivers on data lines");
  rd_drive_a: assert property (dev_ad_oe |-> !$past(rd_n))
    else $error("device drives outside fetch");
  rd_start_a: assert property ($fell(rd_n) && !cs_n && VCC_OK_IN |=> dev_ad_oe)
    else $error("device silent in fetch");
  rd_end_a: assert property ($rose(rd_n) |=> !dev_ad_oe)
    else $error("device drives after fetch");
  no_access_a: assert property (!rd_n && (cs_n || !VCC_OK_IN) |=> !dev_ad_oe)
    else $error("device answers blocked fetch");
  // flags only clear through a selected bus cycle, so release follows one
  irq_release_a: assert property ($fell(irq_oe) |-> !$past(cs_n) || !$past(cs_n, 2))
    else $error("interrupt released without access");
  supply_cause_a: assert property ($rose(supply_oe) |-> !$past(VCC_OK_IN) && !$past(wake_key_n, 2))
    else $error("supply-on without wake key");
  // reset counts in the window: the enable flop comes out of reset one cycle late
  sq_on_a: assert property ((RST_N_IN && VCC_OK_IN)[*2] |-> square_wave_oe)
    else $error("square wave undriven while supplied");
  sq_off_a: assert property ((!VCC_OK_IN && !AUX_SUPPLY_IN)[*2] |-> !square_wave_oe)
    else $error("square wave driven unpowered");
endmodule // rtc_pin_monitor

// ===== verif/rtc_pin_control_logic_tb_top.sv
// self-checking bench joining host end and device end over the pin link
`timescale 1ns/100ps
module rtc_pin_control_logic_tb_top import rtc_pin_pkg::*; ;
  logic clk, rst_n, vcc, aux, cyc, stb, we, ack, div;
  logic [2:0] ev;
  logic [3:0] adr, sel;
  logic [31:0] dat, dout;
  logic [7:0] q;
  int mismatches = 0;
  int check_count = 0;
  int ticks = 0;
  rtc_pin_if pins ();
  rtc_host_end #(.STROBE_CYCLES_P(STROBE_CYCLES)) rtc_host_end_i (.SYS_CLK_IN(clk),
    .RST_N_IN(rst_n), .PINS(pins), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(sel), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack));
  // short divider step keeps square wave periods countable
  rtc_device_end #(.TICK_CYCLES_P(2)) rtc_device_end_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .PINS(pins), .VCC_OK_IN(vcc), .AUX_SUPPLY_IN(aux), .EVENT_FLAGS_IN(ev),
    .DIVIDER_RUN_OUT(div));
  rtc_pin_monitor rtc_pin_monitor_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .VCC_OK_IN(vcc),
    .AUX_SUPPLY_IN(aux), .ale(pins.ale), .cs_n(pins.cs_n), .wr_n(pins.wr_n),
    .rd_n(pins.rd_n), .host_ad_oe(pins.host_ad_oe), .dev_ad_oe(pins.dev_ad_oe),
    .irq_oe(pins.irq_oe), .supply_oe(pins.supply_oe), .square_wave_oe(pins.square_wave_oe),
    .wake_key_n(pins.wake_key_n));
  // free-running 10 MHz clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  // classic single wishbone cycle; a lost answer is left to the hang guard
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = dout;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  // one pin-bus transfer through the host command register, then poll busy
  task automatic rtc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] s;
    wb(1, HOST_CMD_ADDR, {14'h0, 1'b1, w, d, a}, s);
    do begin
      wb(0, HOST_STATUS_ADDR, 32'h0, s);
    end while (s[STAT_BUSY_BIT] !== 1'b0);
    q = s[STAT_DATA_LSB +: 8];
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    rtc(0, a, 8'h00);
    chk(nm, e, q);
  endtask
  // wipe or wake input held low long enough to pass the synchroniser
  task automatic press(input logic wipe);
    if (wipe) pins.user_ram_wipe_n <= 0;
    else pins.wake_key_n <= 0;
    idle(8);
    pins.user_ram_wipe_n <= 1;
    pins.wake_key_n <= 1;
    idle(4);
  endtask
  // counts output changes over 256 cycles; a stopped output gives zero
  task automatic sq_chk(input string nm, input int e);
    int c = 0;
    logic p;
    p = pins.square_wave_out;
    repeat (256) begin
      @(posedge clk);
      c += (pins.square_wave_out !== p);
      p = pins.square_wave_out;
    end
    chk(nm, e, c);
  endtask
  task automatic t_power_up();
    idle(2);
    chk("divider run", 1, div);
    rd_chk("reg a", REG_A_ADDR, 8'h20);
    rtc(1, REG_A_ADDR, 8'h30);
    rd_chk("ext ctrl", EXT_CTRL_ADDR, 8'h40);
  endtask
  task automatic t_ram();
    rtc(1, RAM_FIRST_ADDR, 8'h5a);
    rd_chk("ram byte", RAM_FIRST_ADDR, 8'h5a);
    press(1);
    rd_chk("ram wiped", RAM_FIRST_ADDR, 8'hff);
    rd_chk("reg a kept", REG_A_ADDR, 8'h30);
    rd_chk("ext kept", EXT_CTRL_ADDR, 8'h40);
    rtc(1, 8'h7f, 8'h00);
    vcc <= 0;
    press(1);
    vcc <= 1;
    idle(4);
    rd_chk("wipe on backup", 8'h7f, 8'hff);
  endtask
  task automatic t_vcc_off();
    rtc(1, 8'h10, 8'h11);
    vcc <= 0;
    rtc(1, 8'h10, 8'h22);
    rd_chk("read below trip", 8'h10, BUS_IDLE_VAL);
    vcc <= 1;
    idle(4);
    rd_chk("write below trip", 8'h10, 8'h11);
  endtask
  task automatic t_irq();
    rtc(1, REG_B_ADDR, 8'h10);
    ev <= 3'b010;
    idle(1);
    ev <= 3'b000;
    idle(4);
    chk("irq masked", 1, pins.irq_line_n);
    ev <= 3'b001;
    idle(1);
    ev <= 3'b000;
    idle(4);
    chk("irq raised", 0, pins.irq_line_n);
    rd_chk("flags", REG_C_ADDR, 8'hb0);
    idle(3);
    chk("irq freed", 1, pins.irq_line_n);
  endtask
  task automatic t_wake();
    logic [31:0] s;
    rtc(1, EXT_CTRL_ADDR, 8'ha0);
    press(0);
    chk("wake as irq", 0, pins.irq_line_n);
    chk("no power on", 1, pins.supply_on_n);
    wb(0, HOST_STATUS_ADDR, 32'h0, s);
    chk("status irq", 1, s[STAT_IRQ_BIT]);
    rtc(1, EXT_CTRL_ADDR, 8'hb0);
    idle(3);
    chk("wake irq freed", 1, pins.irq_line_n);
    vcc <= 0;
    press(0);
    chk("power on", 0, pins.supply_on_n);
    wb(0, HOST_STATUS_ADDR, 32'h0, s);
    chk("status supply", 1, s[STAT_SUPPLY_BIT]);
    vcc <= 1;
    idle(4);
    rtc(1, EXT_CTRL_ADDR, 8'ha1);
    idle(3);
    chk("power off", 1, pins.supply_on_n);
    // unused key: aux enable off and the pin tied low for the rest of the run
    rtc(1, EXT_CTRL_ADDR, 8'h00);
    pins.wake_key_n <= 0;
    vcc <= 0;
    idle(8);
    chk("tied key no power", 1, pins.supply_on_n);
    vcc <= 1;
    idle(4);
  endtask
  task automatic t_sq();
    vcc <= 0;
    idle(2);
    vcc <= 1;
    idle(4);
    sq_chk("fast clock", 128);
    rtc(1, EXT_CTRL_ADDR, 8'h80);
    sq_chk("wave off", 0);
    chk("driven while up", 1, pins.square_wave_oe);
    rtc(1, REG_B_ADDR, 8'h08);
    rtc(1, REG_A_ADDR, 8'h30);
    sq_chk("tap off", 0);
    rtc(1, REG_A_ADDR, 8'h31);
    sq_chk("tap rate 1", 1);
    for (int r = 3; r < 7; r++) begin
      rtc(1, REG_A_ADDR, 8'h30 | r[7:0]);
      sq_chk("tap rate", 256 >> r);
    end
    rtc(1, REG_B_ADDR, 8'h00);
    vcc <= 0;
    aux <= 0;
    idle(4);
    chk("undriven below trip", 0, pins.square_wave_oe);
    aux <= 1;
    vcc <= 1;
    idle(4);
    rtc(1, EXT_CTRL_ADDR, 8'hc0);
    vcc <= 0;
    idle(4);
    chk("backup fast oe", 1, pins.square_wave_oe);
    sq_chk("backup fast clock", 128);
    vcc <= 1;
  endtask
  // reset for two cycles, then the scenarios in turn
  initial begin
    rst_n = 0;
    vcc = 1;
    aux = 1;
    ev = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    sel = 0;
    dat = 0;
    pins.wake_key_n = 1;
    pins.user_ram_wipe_n = 1;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    t_power_up();
    t_ram();
    t_vcc_off();
    t_irq();
    t_wake();
    t_sq();
    wrap_up();
  end
endmodule // rtc_pin_control_logic_tb_top
